// *** vsm_pkg.sv ***
// shared constants, types and helpers for the output-voltage scale and floor commands
package vsm_pkg;

  // command codes
  localparam logic [7:0]  VSM_CMD_SCALE_MON = 8'h2a;
  localparam logic [7:0]  VSM_CMD_OUTPUT_VOLTAGE_FLOOR  = 8'h2b;

  // monitor scale word layout
  localparam int          VSM_EXP_MSB       = 15;
  localparam int          VSM_EXP_LSB       = 11;
  localparam int          VSM_MANT_MSB      = 3;
  localparam logic [4:0]  VSM_MON_EXP       = 5'h1d;
  localparam logic [6:0]  VSM_MON_PAD       = 7'h00;

  // floor word layout
  localparam int          VSM_MIN_MSB       = 11;
  localparam logic [3:0]  VSM_MIN_PAD       = 4'h0;

  // reset values
  localparam logic [3:0]  VSM_MANT_RST      = 4'h1;
  localparam logic [11:0] VSM_MIN_RST       = 12'h000;

  // divider gain codes: 0 = 0.125, 1 = 0.25, 2 = 0.5, 3 = 1.0
  localparam logic [1:0]  VSM_GAIN_0125     = 2'h0;
  localparam logic [1:0]  VSM_GAIN_0250     = 2'h1;
  localparam logic [1:0]  VSM_GAIN_0500     = 2'h2;
  localparam logic [1:0]  VSM_GAIN_1000     = 2'h3;
  localparam logic [3:0]  VSM_GAIN1_LO      = 4'h2;
  localparam logic [3:0]  VSM_GAIN2_LO      = 4'h4;
  localparam logic [3:0]  VSM_GAIN3_LO      = 4'h8;

  // timing
  localparam int          VSM_CLK_NS        = 100;
  localparam int          VSM_SLEW_STEP_NS  = 1000;
  localparam logic [7:0]  VSM_SLEW_STEP_CYC = 8'((VSM_SLEW_STEP_NS + VSM_CLK_NS - 1) / VSM_CLK_NS);
  localparam logic [1:0]  VSM_BOOT_CYC      = 2'h3;

  // one bus transaction as handed over by the command engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } vsm_req_s;

  // answer to a transaction, one cycle later
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] data;
  } vsm_rsp_s;

  // sticky status flags
  typedef struct packed {
    logic nota;
    logic vout;
    logic vout_minmax;
    logic cml_data;
  } vsm_stat_s;

  // mantissa to largest supported divider gain not above it
  function automatic logic [1:0] vsm_gain(input logic [3:0] m);
    if (m >= VSM_GAIN3_LO) vsm_gain = VSM_GAIN_1000;
    else if (m >= VSM_GAIN2_LO) vsm_gain = VSM_GAIN_0500;
    else if (m >= VSM_GAIN1_LO) vsm_gain = VSM_GAIN_0250;
    else vsm_gain = VSM_GAIN_0125;
  endfunction

  // fixed mantissa restored for each supported gain
  function automatic logic [3:0] vsm_restore(input logic [1:0] g);
    vsm_restore = 4'h1 << g;
  endfunction

  // linear word value expressed in units of 2^-3
  function automatic logic signed [31:0] vsm_lin11(input logic [15:0] w);
    logic signed [31:0] m;
    logic signed [31:0] sh;
    m  = 32'(signed'(w[10:0]));
    sh = 32'(signed'(w[VSM_EXP_MSB:VSM_EXP_LSB])) + 32'sd3;
    if (sh >= 0) vsm_lin11 = m <<< sh[4:0];
    else vsm_lin11 = m >>> 5'(-sh);
  endfunction

endpackage

// *** vsm_sync2.sv ***
// two-flop synchroniser for a pin level
`timescale 1ns/1ns
module vsm_sync2 (
  input  wire logic clk,     // system clock
  input  wire logic sys_rst, // synchronous reset
  input  wire logic d,       // asynchronous level
  output logic      q        // synchronised level
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** vsm_slew.sv ***
// output target ramp, one lsb per step period
`timescale 1ns/1ns
module vsm_slew import vsm_pkg::*; (
  input  wire logic        clk,     // system clock
  input  wire logic        sys_rst, // synchronous reset
  input  wire logic [11:0] goal,    // wanted target
  output logic      [11:0] level    // ramped target
);
  logic [7:0] tick;
  wire        step_now = (tick == VSM_SLEW_STEP_CYC - 8'h01);

  // step timer and ramp; a large jump takes many steps on purpose
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick  <= 8'h00;
      level <= VSM_MIN_RST;
    end else begin
      tick <= step_now ? 8'h00 : tick + 8'h01;
      if (step_now && level < goal) level <= level + 12'h001;
      else if (step_now && level > goal) level <= level - 12'h001;
    end
  end
endmodule

// *** vsm_cmds.sv ***
// monitor scale and output floor command registers
// Function
// - read 2a always, write only with external divider
// - internal divider: monitor follows loop, read-only
// - external divider: monitor value used internally
// - exponent fixed at minus three
// - bits 10:4 read zero, read-only
// - no override: mantissa from voltage-select pin
// - override latched at reset enables bus mantissa
// - store mantissa exactly, drive largest gain not above it
// - gain bands and restore values 1,2,4,8
// - floor at 2b, read and write word
// - floor updates on the fly, nvm default
// - floor limit bits 11:0, upper zero
// - target below floor: warn, move to floor
// - warning sets three status bits, alerts host
// - floor written above target: same warning
// - floor outside range rejected, flagged, alerted
`timescale 1ns/1ns
module vsm_cmds import vsm_pkg::*; (
  input  wire logic        clk,                   // system clock, 10 MHz
  input  wire logic        sys_rst,               // synchronous reset, stands for the vcc reset
  input  wire vsm_req_s    req,                   // one-cycle transaction from the command engine
  input  wire logic        feedback_select_strap, // pin: 1 selects external divider
  input  wire logic [3:0]  voltage_select_pin,    // detected resistor code of the select pin
  input  wire logic        strap_override_bit,    // override bit as held in nvm
  input  wire logic [3:0]  nvm_scale_mant,        // nvm monitor mantissa
  input  wire logic [11:0] nvm_vout_floor,        // nvm or pin-detected floor
  input  wire logic [3:0]  scale_loop_mant,       // loop scale mantissa
  input  wire logic [11:0] vmax_low,              // lowest valid limit value
  input  wire logic [11:0] vmax_high,             // highest valid limit value
  input  wire logic        converting,            // power conversion active
  input  wire logic [11:0] target_req,            // requested output target
  input  wire logic        clear_status,          // clears the sticky flags
  output vsm_rsp_s         rsp,                   // transaction answer
  output logic [1:0]       monitor_gain_sel,      // divider gain in use
  output logic [3:0]       scale_mant_eff,        // scale mantissa in use
  output logic [11:0]      vout_floor_value,      // floor register
  output logic [11:0]      vout_target,           // ramped output target
  output vsm_stat_s        status,                // sticky status flags
  output logic             alert_n                // host alert, low while any flag set
);

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } vsm_state_e;

  vsm_state_e state;
  vsm_state_e next_state;
  logic [1:0] boot_cnt;
  logic       ext_fb_pin;
  logic       ext_fb;
  logic       ovrd_lat;
  logic [3:0] mon_mant;
  logic [3:0] next_mon_mant;
  logic [11:0] next_floor;
  logic [11:0] slew_level;
  vsm_rsp_s   next_rsp;
  vsm_stat_s  next_stat;

  // strap pin arrives from outside the clock domain
  vsm_sync2 u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (feedback_select_strap),
    .q       (ext_fb_pin)
  );

  // command decode
  wire        running    = (state == ST_RUN);
  wire        boot_done  = (state == ST_LOAD) && (boot_cnt == VSM_BOOT_CYC);
  wire        any_req    = req.wr || req.rd;
  wire        hit_mon    = (req.code == VSM_CMD_SCALE_MON);
  wire        hit_min    = (req.code == VSM_CMD_OUTPUT_VOLTAGE_FLOOR);
  wire        wr_mon     = running && req.wr && hit_mon;
  wire        wr_min     = running && req.wr && hit_min;
  wire        rd_hit     = running && req.rd && (hit_mon || hit_min);
  wire        bad_code   = running && any_req && !hit_mon && !hit_min;

  wire logic signed [31:0] mon_val = vsm_lin11(req.data);
  // a fraction dropped by a negative shift makes the value invalid
  wire logic signed [5:0]  mon_sh  = 6'(signed'(req.data[VSM_EXP_MSB:VSM_EXP_LSB])) + 6'sd3;
  wire logic signed [31:0] mon_raw = 32'(signed'(req.data[10:0]));
  wire        mon_exact  = (mon_sh >= 6'sd0) || ((mon_val <<< 5'(-mon_sh)) == mon_raw);
  wire        mon_val_ok = (mon_val >= 0) && (mon_val <= 32'sd15) && mon_exact;

  // and only with override latched at reset
  wire        mon_wr_ok  = wr_mon && ext_fb && ovrd_lat && mon_val_ok;
  wire        mon_wr_bad = wr_mon && !mon_wr_ok;

  // floor range follows the limit range
  wire [11:0] min_val    = req.data[VSM_MIN_MSB:0];
  wire        min_in_rng = (min_val >= vmax_low) && (min_val <= vmax_high)
                           && (req.data[15:12] == VSM_MIN_PAD);
  wire        min_wr_ok  = wr_min && min_in_rng;
  wire        min_wr_bad = wr_min && !min_in_rng;

  wire        floor_hit  = running && converting && (target_req < vout_floor_value);
  wire        min_above  = min_wr_ok && converting && (min_val > target_req);
  wire        warn_evt   = floor_hit || min_above;
  wire        bad_evt    = mon_wr_bad || min_wr_bad || bad_code;

  // clamp the goal to the floor
  wire [11:0] floor_use  = min_above ? min_val : vout_floor_value;
  wire [11:0] slew_goal  = (converting && target_req < floor_use) ? floor_use : target_req;

  // read data; unused bits are constant zero
  // fixed exponent
  wire [15:0] mon_word   = {VSM_MON_EXP, VSM_MON_PAD, mon_mant};
  wire [15:0] min_word   = {VSM_MIN_PAD, vout_floor_value};
  wire [15:0] rd_word    = hit_mon ? mon_word : min_word;

  // boot sequencing: wait for the strap synchroniser to settle
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: if (boot_done) next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_LOAD;
    endcase
  end

  // monitor mantissa source selection
  always_comb begin
    next_mon_mant = mon_mant;
    if (boot_done) begin
      if (!ext_fb_pin) next_mon_mant = scale_loop_mant;
      else if (!strap_override_bit) next_mon_mant = voltage_select_pin;
      else next_mon_mant = vsm_restore(vsm_gain(nvm_scale_mant));
    end else if (running && !ext_fb) begin
      next_mon_mant = scale_loop_mant;
    end else if (mon_wr_ok) begin
      next_mon_mant = mon_val[VSM_MANT_MSB:0];
    end
  end

  // floor register source selection
  always_comb begin
    next_floor = vout_floor_value;
    // default from nvm or pin detection
    if (boot_done) next_floor = nvm_vout_floor;
    // written value takes effect at once
    else if (min_wr_ok) next_floor = min_val;
  end

  // answer for the transaction of this cycle
  always_comb begin
    next_rsp       = '0;
    next_rsp.valid = any_req;
    next_rsp.ack   = rd_hit || mon_wr_ok || min_wr_ok;
    next_rsp.data  = rd_hit ? rd_word : 16'h0000;
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    next_stat = clear_status ? '0 : status;
    if (warn_evt) begin
      next_stat.nota        = 1'b1;
      next_stat.vout        = 1'b1;
      next_stat.vout_minmax = 1'b1;
    end
    if (bad_evt) next_stat.cml_data = 1'b1;
  end

  // state and boot counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state    <= ST_LOAD;
      boot_cnt <= 2'h0;
    end else begin
      state    <= next_state;
      boot_cnt <= boot_done ? boot_cnt : boot_cnt + 2'h1;
    end
  end

  // straps caught once at end of boot, held until next reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_fb   <= 1'b0;
      ovrd_lat <= 1'b0;
    end else if (boot_done) begin
      ext_fb   <= ext_fb_pin;
      ovrd_lat <= strap_override_bit;
    end
  end

  // command registers and answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_mant         <= VSM_MANT_RST;
      vout_floor_value <= VSM_MIN_RST;
      rsp              <= '0;
    end else begin
      mon_mant         <= next_mon_mant;
      vout_floor_value <= next_floor;
      rsp              <= next_rsp;
    end
  end

  // scale in use and divider drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scale_mant_eff   <= VSM_MANT_RST;
      monitor_gain_sel <= VSM_GAIN_0125;
    end else begin
      scale_mant_eff   <= ext_fb ? mon_mant : scale_loop_mant;
      monitor_gain_sel <= vsm_gain(ext_fb ? mon_mant : scale_loop_mant);
    end
  end

  // flags and alert; alert is registered from the same next value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status      <= '0;
      alert_n     <= 1'b1;
      vout_target <= VSM_MIN_RST;
    end else begin
      status      <= next_stat;
      alert_n     <= ~(|next_stat);
      vout_target <= slew_level;
    end
  end

  vsm_slew u_slew (
    .clk     (clk),
    .sys_rst (sys_rst),
    .goal    (slew_goal),
    .level   (slew_level)
  );

  // checks on the command behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_mon_write_ok;
    mon_wr_ok;
  endsequence

  sequence s_mon_read_back;
    ##[1:8] (req.rd && hit_mon && !warn_evt) ##1 rsp.valid;
  endsequence

  property p_mon_exp;
    rd_hit && hit_mon |=> rsp.ack && rsp.data[15:11] == 5'h1d;
  endproperty
  a_mon_exp: assert property (p_mon_exp) else $error("monitor exponent not fixed");

  property p_mon_pad;
    rd_hit && hit_mon |=> rsp.data[10:4] == 7'h00;
  endproperty
  a_mon_pad: assert property (p_mon_pad) else $error("monitor padding not zero");

  property p_mon_wr_internal;
    wr_mon && !ext_fb |=> rsp.valid && !rsp.ack;
  endproperty
  a_mon_wr_internal: assert property (p_mon_wr_internal) else $error("write taken on internal divider");

  property p_follow_loop;
    running && !ext_fb ##1 running |-> mon_mant == $past(scale_loop_mant);
  endproperty
  a_follow_loop: assert property (p_follow_loop) else $error("monitor not following loop");

  property p_eff_scale;
    running && ext_fb |=> scale_mant_eff == $past(mon_mant);
  endproperty
  a_eff_scale: assert property (p_eff_scale) else $error("monitor value not in use");

  property p_pin_load;
    boot_done && ext_fb_pin && !strap_override_bit |=> mon_mant == $past(voltage_select_pin);
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("pin code not loaded");

  property p_ovrd_gate;
    mon_wr_ok |-> ovrd_lat && ext_fb;
  endproperty
  a_ovrd_gate: assert property (p_ovrd_gate) else $error("mantissa write without override");

  property p_exact_store;
    logic [3:0] v;
    (s_mon_write_ok, v = mon_val[3:0]) ##1 (!mon_wr_ok && ext_fb)[*1] |-> mon_mant == v;
  endproperty
  a_exact_store: assert property (p_exact_store) else $error("mantissa not stored exactly");

  property p_gain_map;
    !sys_rst |=> monitor_gain_sel == vsm_gain($past(ext_fb ? mon_mant : scale_loop_mant));
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("gain band wrong");

  property p_floor_read;
    rd_hit && hit_min |=> rsp.data == {4'h0, $past(vout_floor_value)};
  endproperty
  a_floor_read: assert property (p_floor_read) else $error("floor read wrong");

  property p_floor_fly;
    min_wr_ok |=> vout_floor_value == $past(min_val);
  endproperty
  a_floor_fly: assert property (p_floor_fly) else $error("floor not updated");

  property p_floor_warn;
    floor_hit |=> status.vout_minmax && status.nota && status.vout && !alert_n;
  endproperty
  a_floor_warn: assert property (p_floor_warn) else $error("floor warning missing");

  property p_set_wins;
    warn_evt && clear_status |=> status.nota && status.vout && status.vout_minmax;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a warning event");

  property p_slew_step;
    $changed(vout_target) |-> (vout_target == $past(vout_target) + 12'h001)
                              || (vout_target == $past(vout_target) - 12'h001);
  endproperty
  a_slew_step: assert property (p_slew_step) else $error("target moved more than one step");

  property p_write_above;
    min_above |=> status.vout_minmax;
  endproperty
  a_write_above: assert property (p_write_above) else $error("floor above target not warned");

  property p_range_reject;
    min_wr_bad |=> !rsp.ack && status.cml_data && $stable(vout_floor_value) && !alert_n;
  endproperty
  a_range_reject: assert property (p_range_reject) else $error("bad floor write not rejected");

endmodule

// *** vsm_host.sv ***
// host model that issues word reads and writes to the command block
`timescale 1ns/1ns
module vsm_host import vsm_pkg::*; (
  input  wire logic     clk, // system clock
  input  wire vsm_rsp_s rsp, // answer from the block
  output vsm_req_s      req  // request to the block
);
  // idle bus until the first transfer
  initial req = '0;

  // one word transfer: request stands one edge, answer taken one edge later
  // caller picks values
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic valid, output logic ack, output logic [15:0] rdata);
    @(posedge clk);
    req <= {wr, ~wr, code, data};
    @(posedge clk);
    // released lines show inverted values so a stale word never looks valid
    req <= {1'b0, 1'b0, ~code, ~data};
    // the answer stands from the taking edge to the next one; take it at that next edge
    @(posedge clk);
    valid = rsp.valid;
    ack   = rsp.ack;
    rdata = rsp.data;
    // step off the edge so callers see settled outputs
    #1;
  endtask
endmodule

// *** tb_vsm_cmds.sv ***
// self-checking bench for the monitor scale and output floor commands
`timescale 1ns/1ns
module tb_vsm_cmds import vsm_pkg::*;;
  logic        clk                   = 1'b0;
  logic        sys_rst               = 1'b1;
  vsm_req_s    req;
  logic        feedback_select_strap = 1'b0;
  logic [3:0]  voltage_select_pin    = 4'h0;
  logic        strap_override_bit    = 1'b0;
  logic [3:0]  nvm_scale_mant        = 4'h0;
  logic [11:0] nvm_vout_floor        = 12'h008;
  logic [3:0]  scale_loop_mant       = 4'h5;
  logic [11:0] vmax_low              = 12'h004;
  logic [11:0] vmax_high             = 12'h080;
  logic        converting            = 1'b0;
  logic [11:0] target_req            = 12'h010;
  logic        clear_status          = 1'b0;
  vsm_rsp_s    rsp;
  logic [1:0]  monitor_gain_sel;
  logic [3:0]  scale_mant_eff;
  logic [11:0] vout_floor_value;
  logic [11:0] vout_target;
  vsm_stat_s   status;
  logic        alert_n;
  int          n_errors              = 0;
  int          n_checks              = 0;
  int          m;

  // 10 MHz clock
  always #50 clk = ~clk;

  vsm_cmds dut_u (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .req                  (req),
    .feedback_select_strap(feedback_select_strap),
    .voltage_select_pin   (voltage_select_pin),
    .strap_override_bit   (strap_override_bit),
    .nvm_scale_mant       (nvm_scale_mant),
    .nvm_vout_floor       (nvm_vout_floor),
    .scale_loop_mant      (scale_loop_mant),
    .vmax_low             (vmax_low),
    .vmax_high            (vmax_high),
    .converting           (converting),
    .target_req           (target_req),
    .clear_status         (clear_status),
    .rsp                  (rsp),
    .monitor_gain_sel     (monitor_gain_sel),
    .scale_mant_eff       (scale_mant_eff),
    .vout_floor_value     (vout_floor_value),
    .vout_target          (vout_target),
    .status               (status),
    .alert_n              (alert_n)
  );

  vsm_host host_u (
    .clk(clk),
    .rsp(rsp),
    .req(req)
  );

  // verdict and end of run, shared by the tests and the watchdog
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer with its answer checked; read data only when accepted
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] data,
                     input logic exp_ack, input logic [15:0] exp_rd);
    logic        v;
    logic        a;
    logic [15:0] d;
    host_u.xfer(wr, code, data, v, a, d);
    chk("rsp_valid", 16'h0001, {15'h0, v});
    chk("rsp_ack", {15'h0, exp_ack}, {15'h0, a});
    if (!wr && exp_ack) chk("rsp_data", exp_rd, d);
  endtask

  task automatic chk_stat(input logic [3:0] exp);
    chk("status", {12'h0, exp}, {12'h0, status});
    chk("alert_n", {15'h0, exp == 4'h0}, {15'h0, alert_n});
  endtask

  task automatic clr();
    @(posedge clk);
    clear_status <= 1'b1;
    @(posedge clk);
    clear_status <= 1'b0;
    @(posedge clk);
  endtask

  // bounded wait for the ramp to land
  task automatic wait_tgt(input logic [11:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && vout_target !== exp; i++) @(posedge clk);
    #1;
    chk("vout_target", {4'h0, exp}, {4'h0, vout_target});
  endtask

  // straps and nvm set during reset, then held through boot
  task automatic boot(input logic fb, input logic ovr, input logic [3:0] pin, input logic [3:0] nm);
    @(posedge clk);
    sys_rst               <= 1'b1;
    feedback_select_strap <= fb;
    strap_override_bit    <= ovr;
    voltage_select_pin    <= pin;
    nvm_scale_mant        <= nm;
    converting            <= 1'b0;
    target_req            <= 12'h010;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // expected divider gain code per mantissa band
  function automatic logic [1:0] band(input int mv);
    band = (mv >= 8) ? 2'h3 : (mv >= 4) ? 2'h2 : (mv >= 2) ? 2'h1 : 2'h0;
  endfunction

  initial begin
    // internal divider: monitor mirrors loop scale, writes refused
    boot(1'b0, 1'b0, 4'h9, 4'h6);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he805);
    chk("gain", 16'h0002, {14'h0, monitor_gain_sel});
    chk("mant_eff", 16'h0005, {12'h0, scale_mant_eff});
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'he803, 1'b0, 16'h0);
    chk_stat(4'h1);
    clr();
    cmd(1'b0, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0, 1'b1, 16'h0008);
    cmd(1'b0, 8'h33, 16'h0, 1'b0, 16'h0);
    clr();
    chk_stat(4'h0);
    wait_tgt(12'h010, 400);
    // floor writes: accepted, then refused at each edge of the range
    cmd(1'b1, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h000c, 1'b1, 16'h0);
    chk("floor", 16'h000c, {4'h0, vout_floor_value});
    cmd(1'b0, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0, 1'b1, 16'h000c);
    cmd(1'b1, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h100c, 1'b0, 16'h0);
    cmd(1'b1, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0081, 1'b0, 16'h0);
    cmd(1'b1, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0003, 1'b0, 16'h0);
    chk_stat(4'h1);
    cmd(1'b0, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0, 1'b1, 16'h000c);
    clr();
    // converting: floor raised above the present target
    @(posedge clk) converting <= 1'b1;
    cmd(1'b1, VSM_CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0018, 1'b1, 16'h0);
    chk_stat(4'he);
    repeat (40) @(posedge clk);
    chk("ramp_mid", 16'h0001, {15'h0, vout_target < 12'h018});
    wait_tgt(12'h018, 120);
    // target above floor clears cleanly, then a drop below the floor warns
    @(posedge clk) target_req <= 12'h020;
    clr();
    #1;
    chk_stat(4'h0);
    @(posedge clk) target_req <= 12'h00c;
    repeat (3) @(posedge clk);
    #1;
    chk_stat(4'he);
    clr();
    #1;
    chk_stat(4'he);
    wait_tgt(12'h018, 80);
    // external divider with override latched at boot: bus owns the mantissa
    boot(1'b1, 1'b1, 4'h9, 4'h6);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he804);
    for (m = 0; m < 16; m++) begin
      cmd(1'b1, VSM_CMD_SCALE_MON, {5'h1d, 7'h0, 4'(m)}, 1'b1, 16'h0);
      cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, {5'h1d, 7'h0, 4'(m)});
      chk("gain", {14'h0, band(m)}, {14'h0, monitor_gain_sel});
      chk("mant_eff", 16'(m), {12'h0, scale_mant_eff});
    end
    // same value in other exponents
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'h0001, 1'b1, 16'h0);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he808);
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'hf002, 1'b1, 16'h0);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he804);
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'h0002, 1'b0, 16'h0);
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'hd808, 1'b1, 16'h0);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he802);
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'hd801, 1'b0, 16'h0);
    // external divider without override: pin decides, bus refused
    boot(1'b1, 1'b0, 4'hb, 4'h6);
    cmd(1'b0, VSM_CMD_SCALE_MON, 16'h0, 1'b1, 16'he80b);
    cmd(1'b1, VSM_CMD_SCALE_MON, 16'he803, 1'b0, 16'h0);
    tally_and_finish();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 100);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
